// ===== dhis_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "dhis_regs.svh"
module dhis_top
  import dhis_pkg::*;
#(
  parameter logic [5:0] I2C_ADDR_BASE = `DHIS_I2C_ADDR_BASE // arbitrary
) (
  input wire logic mclk, // core clock, 250 MHz
  input wire logic rst, // async reset, active high
  input wire logic sclk, // serial link clock, same wire as bus bit 0
  input wire logic [1:0] interface_select_straps, // mode straps
  input wire logic chip_select_n, // chip select, active low
  input wire logic hw_init_n, // chip initialization, active low
  input wire logic data_command_sel, // 1 data, 0 command
  input wire logic write_read_ctl, // 8080 write strobe or 6800 dir
  input wire logic read_strobe_n, // 8080 read strobe or 6800 enable
  input wire logic [7:0] host_data_in, // bus level seen at pins
  output logic [7:0] host_data_out, // bus drive value
  output logic [7:0] host_data_oe, // per-line drive enable
  input wire logic [7:0] rd_data, // core byte returned on reads
  output logic rd_take, // pulse: read byte consumed
  output logic rx_valid, // pulse: rx_byte valid
  output logic [7:0] rx_byte, // received byte
  output logic rx_is_data, // 1 display data, 0 command
  output logic chip_init, // level: initialization requested
  output logic [1:0] if_mode, // latched interface mode
  output logic addr_lsb_strap // latched i2c address lsb
);
  // --------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------
  logic [1:0] strap_s;
  logic cs_n_s, init_n_s, dc_s, wr_s, rd_s;
  logic [7:0] data_s;
  logic tog_s;
  logic [7:0] spi_byte;
  logic spi_is_data, spi_tog;

  dhis_sync #(.W(15)) u_pin_sync (
    .clk(mclk),
    .rst(rst),
    .d({interface_select_straps, chip_select_n, hw_init_n,
        data_command_sel, write_read_ctl, read_strobe_n, host_data_in}),
    .q({strap_s, cs_n_s, init_n_s, dc_s, wr_s, rd_s, data_s})
  );

  dhis_spi_rx u_spi_rx (
    .sclk(sclk),
    .rst(rst),
    .chip_select_n(chip_select_n),
    .serial_data_in(host_data_in[`DHIS_BIT_SERIAL_DATA_IN]),
    .data_command_sel(data_command_sel),
    .byte_r(spi_byte),
    .is_data_r(spi_is_data),
    .done_tog_r(spi_tog)
  );

  dhis_sync #(.W(1)) u_tog_sync (
    .clk(mclk),
    .rst(rst),
    .d(spi_tog),
    .q(tog_s)
  );

  // --------------------------------------------------------------------
  // mode straps and initialization
  // --------------------------------------------------------------------
  dhis_mode_t mode_r;
  logic loaded_r, lsb_r, init_r;
  logic sel, run;

  // straps are re-read while initialization is held and after reset; the
  // reset value of the synchroniser is no strap, so init_r keeps the load
  // open until the synchronised pins show real levels
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode_r <= `DHIS_MODE_SERIAL;
      lsb_r <= 1'b0;
      loaded_r <= 1'b0;
    end else if (!loaded_r || init_r || !init_n_s) begin
      mode_r <= strap_s;
      lsb_r <= dc_s;
      loaded_r <= 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      init_r <= 1'b1;
    end else begin
      init_r <= ~init_n_s;
    end
  end

  assign run = loaded_r && !init_r;
  assign sel = !cs_n_s && run;
  assign chip_init = init_r;
  assign if_mode = mode_r;
  assign addr_lsb_strap = lsb_r;

  // --------------------------------------------------------------------
  // parallel 8080 / 6800 port
  // --------------------------------------------------------------------
  logic is80, is68;
  logic wr_p_r, rd_p_r;
  logic wr_act_r, rd_act_r;
  logic par_valid;
  logic par_rd_start, par_wr_start, par_end;

  assign is80 = (mode_r == `DHIS_MODE_P8080);
  assign is68 = (mode_r == `DHIS_MODE_P6800);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_p_r <= 1'b1;
      rd_p_r <= 1'b1;
    end else begin
      wr_p_r <= wr_s;
      rd_p_r <= rd_s;
    end
  end

  always_comb begin
    par_rd_start = 1'b0;
    par_wr_start = 1'b0;
    par_end = 1'b0;
    if (is80) begin
      par_wr_start = sel && wr_p_r && !wr_s;
      par_rd_start = sel && rd_p_r && !rd_s;
      par_end = (wr_s && !wr_p_r) || (rd_s && !rd_p_r) || cs_n_s;
    end else if (is68) begin
      par_wr_start = sel && !rd_p_r && rd_s && !wr_s;
      par_rd_start = sel && !rd_p_r && rd_s && wr_s;
      par_end = (!rd_s && rd_p_r) || cs_n_s;
    end
  end

  // write data is taken at the trailing edge, when the host's bus has
  // had the whole strobe to settle through the synchroniser
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_act_r <= 1'b0;
      rd_act_r <= 1'b0;
    end else if (!run) begin
      wr_act_r <= 1'b0;
      rd_act_r <= 1'b0;
    end else if (par_wr_start) begin
      wr_act_r <= 1'b1;
    end else if (par_rd_start) begin
      rd_act_r <= 1'b1;
    end else if (par_end) begin
      wr_act_r <= 1'b0;
      rd_act_r <= 1'b0;
    end
  end

  // a deselect aborts a pending write rather than completing it
  assign par_valid = wr_act_r && par_end && !cs_n_s;

  // --------------------------------------------------------------------
  // serial byte crossing
  // --------------------------------------------------------------------
  logic tog_p_r, ser_valid;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tog_p_r <= 1'b0;
    end else begin
      tog_p_r <= tog_s;
    end
  end

  // the held spi word is stable long before its toggle is seen here
  assign ser_valid = (tog_s != tog_p_r) && run &&
                     (mode_r == `DHIS_MODE_SERIAL);

  // --------------------------------------------------------------------
  // i2c slave, oversampled on the core clock
  // --------------------------------------------------------------------
  dhis_i2c_st_t i2c_st_r;
  logic [7:0] i2c_sh_r;
  logic [3:0] i2c_cnt_r;
  logic [1:0] i2c_idx_r;
  logic i2c_dc_r, i2c_ack_r, i2c_valid_r;
  logic scl_p_r, sda_p_r;
  logic scl, sda, scl_rise, scl_fall, i2c_start, i2c_stop, isi2c;

  assign isi2c = (mode_r == `DHIS_MODE_I2C) && sel;
  assign scl = data_s[`DHIS_BIT_SCLK];
  assign sda = data_s[`DHIS_BIT_SERIAL_DATA_IN];
  assign scl_rise = scl && !scl_p_r;
  assign scl_fall = !scl && scl_p_r;
  assign i2c_start = scl && scl_p_r && sda_p_r && !sda;
  assign i2c_stop = scl && scl_p_r && !sda_p_r && sda;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      scl_p_r <= 1'b1;
      sda_p_r <= 1'b1;
    end else begin
      scl_p_r <= scl;
      sda_p_r <= sda;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      i2c_st_r <= I2C_IDLE;
      i2c_sh_r <= '0;
      i2c_cnt_r <= '0;
      i2c_idx_r <= `DHIS_I2C_IDX_ADDR;
      i2c_dc_r <= 1'b0;
      i2c_ack_r <= 1'b0;
      i2c_valid_r <= 1'b0;
    end else begin
      i2c_valid_r <= 1'b0;
      if (!isi2c || i2c_stop) begin
        i2c_st_r <= I2C_IDLE;
        i2c_ack_r <= 1'b0;
      end else if (i2c_start) begin
        i2c_st_r <= I2C_RX;
        i2c_cnt_r <= '0;
        i2c_idx_r <= `DHIS_I2C_IDX_ADDR;
        i2c_ack_r <= 1'b0;
      end else begin
        unique case (i2c_st_r)
          I2C_IDLE: begin
            i2c_ack_r <= 1'b0;
          end
          I2C_RX: begin
            if (scl_rise) begin
              i2c_sh_r <= {i2c_sh_r[6:0], sda};
              i2c_cnt_r <= i2c_cnt_r + 4'h1;
            end else if (scl_fall && i2c_cnt_r == `DHIS_BYTE_BITS) begin
              i2c_cnt_r <= '0;
              if (i2c_idx_r == `DHIS_I2C_IDX_ADDR) begin
                // only write transfers to our address are acknowledged
                if (i2c_sh_r == {I2C_ADDR_BASE, lsb_r, 1'b0}) begin
                  i2c_st_r <= I2C_ACK;
                  i2c_ack_r <= 1'b1;
                end else begin
                  i2c_st_r <= I2C_IDLE;
                end
              end else begin
                if (i2c_idx_r == `DHIS_I2C_IDX_CTRL) begin
                  i2c_dc_r <= i2c_sh_r[`DHIS_I2C_DC_BIT];
                end else begin
                  i2c_valid_r <= 1'b1;
                end
                i2c_st_r <= I2C_ACK;
                i2c_ack_r <= 1'b1;
              end
            end
          end
          I2C_ACK: begin
            if (scl_fall) begin
              i2c_ack_r <= 1'b0;
              i2c_st_r <= I2C_RX;
              if (i2c_idx_r != `DHIS_I2C_IDX_DATA) begin
                i2c_idx_r <= i2c_idx_r + 2'h1;
              end
            end
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------
  // byte delivery to the core
  // --------------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_valid <= 1'b0;
      rx_byte <= '0;
      rx_is_data <= 1'b0;
    end else begin
      rx_valid <= par_valid || ser_valid || i2c_valid_r;
      if (par_valid) begin
        rx_byte <= data_s;
        rx_is_data <= dc_s;
      end else if (ser_valid) begin
        rx_byte <= spi_byte;
        rx_is_data <= spi_is_data;
      end else if (i2c_valid_r) begin
        rx_byte <= i2c_sh_r;
        rx_is_data <= i2c_dc_r;
      end
    end
  end

  // --------------------------------------------------------------------
  // bus drive
  // --------------------------------------------------------------------
  assign rd_take = par_rd_start;

  // parallel reads drive all eight lines; i2c only pulls bit 2 low, and
  // serial mode never drives, which keeps the unconnected bit 2 quiet
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      host_data_out <= '0;
      host_data_oe <= '0;
    end else if (par_rd_start) begin
      host_data_out <= rd_data;
      host_data_oe <= 8'hFF;
    end else if (rd_act_r && !par_end && run) begin
      host_data_oe <= 8'hFF;
    end else begin
      host_data_out <= '0;
      host_data_oe <= {5'h00, i2c_ack_r, 2'h0};
    end
  end
endmodule
`default_nettype wire

// ===== dhis_regs.svh
`ifndef DHIS_REGS_SVH
`define DHIS_REGS_SVH

// ----------------------------------------------------------------------
// interface select strap codes
// ----------------------------------------------------------------------
`define DHIS_MODE_SERIAL 2'h0
`define DHIS_MODE_I2C 2'h1
`define DHIS_MODE_P6800 2'h2
`define DHIS_MODE_P8080 2'h3

// ----------------------------------------------------------------------
// shared bus bit positions
// ----------------------------------------------------------------------
`define DHIS_BIT_SCLK 0
`define DHIS_BIT_SERIAL_DATA_IN 1
`define DHIS_BIT_SDA_OUT 2

// ----------------------------------------------------------------------
// serial and i2c framing
// ----------------------------------------------------------------------
`define DHIS_BYTE_BITS 4'h8
`define DHIS_I2C_DC_BIT 6
`define DHIS_I2C_IDX_ADDR 2'h0
`define DHIS_I2C_IDX_CTRL 2'h1
`define DHIS_I2C_IDX_DATA 2'h2
`define DHIS_I2C_ADDR_BASE 6'h1E

`endif

// ===== dhis_pkg.sv
`default_nettype none
package dhis_pkg;
  typedef logic [1:0] dhis_mode_t;
  typedef enum {I2C_IDLE, I2C_RX, I2C_ACK} dhis_i2c_st_t;
endpackage
`default_nettype wire

// ===== dhis_sync.sv
`timescale 1ns/1ps
`default_nettype none
module dhis_sync #(
  parameter int W = 1
) (
  input wire logic clk, // destination clock
  input wire logic rst, // async reset, active high
  input wire logic [W-1:0] d, // asynchronous level in
  output logic [W-1:0] q // synchronised level out
);
  logic [W-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ===== dhis_spi_rx.sv
`timescale 1ns/1ps
`default_nettype none
module dhis_spi_rx (
  input wire logic sclk, // serial clock, bus bit 0
  input wire logic rst, // async reset, active high
  input wire logic chip_select_n, // frame select pin, active low
  input wire logic serial_data_in, // serial data, bus bit 1
  input wire logic data_command_sel, // 1 data, 0 command
  output logic [7:0] byte_r, // last complete byte, held
  output logic is_data_r, // data/command flag of byte_r
  output logic done_tog_r // toggles once per complete byte
);
  logic [6:0] shift_r;
  logic [2:0] cnt_r;
  logic clr;

  // the link clock stops outside frames, so the frame ends by its own
  // select line rather than by any further clock edge
  assign clr = rst | chip_select_n;

  always_ff @(posedge sclk or posedge clr) begin
    if (clr) begin
      shift_r <= '0;
      cnt_r <= '0;
    end else begin
      shift_r <= {shift_r[5:0], serial_data_in};
      cnt_r <= cnt_r + 3'h1;
    end
  end

  // output word is not cleared by deselect, so no false toggle appears
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      byte_r <= '0;
      is_data_r <= 1'b0;
      done_tog_r <= 1'b0;
    end else if (!chip_select_n && cnt_r == 3'h7) begin
      byte_r <= {shift_r, serial_data_in};
      is_data_r <= data_command_sel;
      done_tog_r <= ~done_tog_r;
    end
  end
endmodule
`default_nettype wire

// ===== dhis_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "dhis_regs.svh"
module dhis_top_chk (
  input wire logic mclk, // core clock
  input wire logic rst, // reset
  input wire logic [1:0] interface_select_straps, // straps
  input wire logic chip_select_n, // select
  input wire logic hw_init_n, // init pin
  input wire logic data_command_sel, // dc pin
  input wire logic write_read_ctl, // wr or dir
  input wire logic read_strobe_n, // rd or enable
  input wire logic [7:0] rd_data, // read byte
  input wire logic [7:0] host_data_out, // drive value
  input wire logic [7:0] host_data_oe, // drive enable
  input wire logic rd_take, // read start
  input wire logic rx_valid, // byte strobe
  input wire logic rx_is_data, // byte kind
  input wire logic chip_init, // init level
  input wire logic [1:0] if_mode, // mode
  input wire logic addr_lsb_strap // address lsb
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // write ends (trailing strobe edges), read starts, select and strap checks
  // ----------------------------------------
  sequence s_wr80;
    $rose(write_read_ctl) && !chip_select_n && if_mode == `DHIS_MODE_P8080;
  endsequence
  sequence s_wr68;
    $fell(read_strobe_n) && !chip_select_n && !write_read_ctl &&
      if_mode == `DHIS_MODE_P6800;
  endsequence
  sequence s_byte;
    rx_valid && rx_is_data == data_command_sel;
  endsequence
  a_wr80_byte: assert property (s_wr80 |-> ##[2:5] s_byte)
    else $error("8080 write gave no byte");
  a_wr68_byte: assert property (s_wr68 |-> ##[2:5] s_byte)
    else $error("6800 write gave no byte");
  a_rd80_start: assert property (rd_take && if_mode == `DHIS_MODE_P8080
    |-> $past(!read_strobe_n) && $past(!chip_select_n))
    else $error("8080 read start without strobe");
  a_rd68_start: assert property (rd_take && if_mode == `DHIS_MODE_P6800
    |-> $past(read_strobe_n && write_read_ctl && !chip_select_n))
    else $error("6800 read start without enable");
  a_read_drive: assert property (rd_take |=>
    host_data_oe == 8'hFF && host_data_out == $past(rd_data))
    else $error("read byte not driven");
  a_cs_quiet: assert property (chip_select_n[*8] |->
    !rx_valid && host_data_oe == 8'h00)
    else $error("activity while deselected");
  a_init_level: assert property (!$past(rst, 4) &&
    $stable(hw_init_n)[*5] |->
    chip_init == !hw_init_n)
    else $error("init level wrong");
  a_mode_load: assert property ((!hw_init_n &&
    $stable(interface_select_straps))[*6] |-> if_mode == interface_select_straps)
    else $error("mode not latched");
  a_lsb_load: assert property ((!hw_init_n && $stable(data_command_sel) &&
    interface_select_straps == `DHIS_MODE_I2C)[*6]
    |-> addr_lsb_strap == data_command_sel)
    else $error("address lsb not latched");
endmodule
bind dhis_top dhis_top_chk dhis_top_chk_inst (.*);
`default_nettype wire

// ===== dhis_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module dhis_host_model (
  input wire logic mclk, // pacing clock
  input wire logic [7:0] bus, // resolved bus
  output logic [1:0] straps, // strap pins
  output logic cs_n, // chip select
  output logic init_n, // init pin
  output logic dc, // data or command
  output logic wr, // wr or dir
  output logic rd_n, // rd or enable
  output logic [7:0] drv, // bus drive value
  output logic hoe // host drives bus
);
  initial begin
    straps = 2'h3;
    cs_n = 1'h1;
    init_n = 1'h1;
    dc = 1'h0;
    wr = 1'h1;
    rd_n = 1'h1;
    drv = 8'h00;
    hoe = 1'h0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic mode(input logic [1:0] m, input logic lsb);
    tick(1);
    straps = m;
    dc = lsb;
    init_n = 1'h0;
    wr = (m == 2'h3);
    rd_n = (m == 2'h3);
    hoe = !m[1];
    drv = 8'h00;
    tick(10);
    init_n = 1'h1;
    tick(12);
  endtask
  // ----------------------------------------
  // parallel cycles, data held well past the strobe
  // ----------------------------------------
  task automatic p80(input logic c, input logic rdq, input logic [7:0] b,
                     input logic d, output logic [7:0] r);
    tick(1);
    cs_n = c;
    dc = d;
    drv = b;
    hoe = !rdq;
    if (rdq) rd_n = 1'h0;
    else wr = 1'h0;
    tick(6);
    r = bus;
    rd_n = 1'h1;
    wr = 1'h1;
    tick(8);
    cs_n = 1'h1;
    hoe = 1'h0;
    tick(2);
  endtask
  task automatic x68(input logic dir, input logic [7:0] b, input logic d,
                     output logic [7:0] r);
    tick(1);
    cs_n = 1'h0;
    wr = dir;
    dc = d;
    drv = b;
    hoe = !dir;
    tick(3);
    rd_n = 1'h1;
    tick(6);
    r = bus;
    rd_n = 1'h0;
    tick(8);
    cs_n = 1'h1;
    hoe = 1'h0;
    tick(2);
  endtask
  // i2c start (stop=0) or stop (stop=1); scl is left low after a start
  task automatic i2c_cond(input logic stop);
    cs_n = 1'h0;
    drv[2] = 1'h1;
    drv[1] = !stop;
    tick(2);
    drv[0] = 1'h1;
    tick(4);
    drv[1] = stop;
    tick(4);
    drv[0] = stop;
    tick(3);
  endtask
  // one i2c byte, msb first, then the ack clock; sda only moves with scl low
  task automatic i2c(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      drv[1] = b[i];
      tick(2);
      drv[0] = 1'h1;
      tick(5);
      drv[0] = 1'h0;
      tick(3);
    end
    drv[1] = 1'h1;
    tick(2);
    drv[0] = 1'h1;
    tick(3);
    ack = !bus[2];
    tick(2);
    drv[0] = 1'h0;
    tick(3);
  endtask
  // link clock only runs inside a frame
  task automatic ser(input logic [7:0] b, input logic d, input int n);
    tick(1);
    cs_n = 1'h0;
    for (int i = 7; i > 7 - n; i--) begin
      drv[1] = b[i];
      dc = (i == 0) ? d : !d;
      #7.5 drv[0] = 1'h1;
      #7.5 drv[0] = 1'h0;
    end
    tick(8);
    cs_n = 1'h1;
    tick(2);
  endtask
endmodule
`default_nettype wire

// ===== dhis_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module dhis_top_bench;
  logic mclk = 1'h0;
  logic rst = 1'h1;
  logic [1:0] straps, if_mode;
  logic cs_n, init_n, dc, wr, rd_n, hoe, rd_take, rx_valid, rx_is_data;
  logic chip_init, lsb;
  logic [7:0] drv, bus, out, oe, rd_data, rx_byte, r;
  logic [8:0] q[$];
  int n_errors = 0;
  int samples_checked = 0;
`define CHK(nm, e, s) begin \
  samples_checked++; \
  if ((s) !== (e)) begin \
    n_errors++; \
    $display("MISMATCH %s exp %h seen %h", nm, e, s); \
  end \
end
  // released host lines show the inverse of their last value
  assign bus = (oe & out) | (~oe & (hoe ? drv : ~drv));
  initial forever #2 mclk = ~mclk;
  dhis_top dhis_top_inst (.mclk(mclk), .rst(rst), .sclk(bus[0]),
    .interface_select_straps(straps), .chip_select_n(cs_n),
    .hw_init_n(init_n), .data_command_sel(dc), .write_read_ctl(wr),
    .read_strobe_n(rd_n), .host_data_in(bus), .host_data_out(out),
    .host_data_oe(oe), .rd_data(rd_data), .rd_take(rd_take),
    .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_is_data(rx_is_data),
    .chip_init(chip_init), .if_mode(if_mode), .addr_lsb_strap(lsb));
  dhis_host_model dhis_host_model_inst (.mclk(mclk), .bus(bus),
    .straps(straps), .cs_n(cs_n), .init_n(init_n), .dc(dc), .wr(wr),
    .rd_n(rd_n), .drv(drv), .hoe(hoe));
  always @(posedge mclk) begin
    if (rx_valid === 1'h1) q.push_back({rx_is_data, rx_byte});
  end
  task automatic got(input logic [8:0] e);
    logic [8:0] s;
    s = 'x;
    if (q.size() > 0) s = q.pop_front();
    `CHK("rx", e, s)
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_modes;
    for (int m = 0; m < 4; m++) begin
      dhis_host_model_inst.mode(m[1:0], m[0]);
      `CHK("mode", m[1:0], if_mode)
      `CHK("init", 1'h0, chip_init)
      if (m == 1) `CHK("lsb", 1'h1, lsb)
    end
  endtask
  task automatic t_p80;
    dhis_host_model_inst.mode(2'h3, 1'h0);
    rd_data = 8'h5A;
    dhis_host_model_inst.p80(1'h0, 1'h0, 8'hA5, 1'h1, r);
    dhis_host_model_inst.p80(1'h0, 1'h0, 8'h3C, 1'h0, r);
    dhis_host_model_inst.p80(1'h1, 1'h0, 8'h77, 1'h1, r);
    dhis_host_model_inst.p80(1'h0, 1'h1, 8'h00, 1'h0, r);
    `CHK("rd80", 8'h5A, r)
    got(9'h1A5);
    got(9'h03C);
    `CHK("extra80", 0, q.size())
  endtask
  task automatic t_p68;
    dhis_host_model_inst.mode(2'h2, 1'h0);
    rd_data = 8'hC3;
    dhis_host_model_inst.x68(1'h0, 8'h96, 1'h0, r);
    dhis_host_model_inst.x68(1'h1, 8'h00, 1'h1, r);
    `CHK("rd68", 8'hC3, r)
    got(9'h096);
    `CHK("extra68", 0, q.size())
  endtask
  task automatic t_ser;
    dhis_host_model_inst.mode(2'h0, 1'h0);
    dhis_host_model_inst.ser(8'h81, 1'h1, 8);
    dhis_host_model_inst.ser(8'hFF, 1'h1, 5);
    dhis_host_model_inst.ser(8'h4E, 1'h0, 8);
    got(9'h181);
    got(9'h04E);
    `CHK("extra_ser", 0, q.size())
  endtask
  task automatic t_i2c;
    logic a;
    dhis_host_model_inst.mode(2'h1, 1'h1);
    dhis_host_model_inst.i2c_cond(1'h0);
    dhis_host_model_inst.i2c(8'h78, a);
    `CHK("nack", 1'h0, a)
    dhis_host_model_inst.i2c_cond(1'h1);
    dhis_host_model_inst.i2c_cond(1'h0);
    dhis_host_model_inst.i2c(8'h7A, a);
    `CHK("ack_addr", 1'h1, a)
    dhis_host_model_inst.i2c(8'h40, a);
    dhis_host_model_inst.i2c(8'hB7, a);
    `CHK("ack_data", 1'h1, a)
    dhis_host_model_inst.i2c_cond(1'h1);
    got(9'h1B7);
    `CHK("extra_i2c", 0, q.size())
  endtask
  task automatic results;
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    rd_data = 8'h00;
    repeat (10) @(negedge mclk);
    `CHK("init_rst", 1'h1, chip_init)
    `CHK("oe_rst", 8'h00, oe)
    repeat (10) @(negedge mclk);
    rst = 1'h0;
    t_modes();
    t_p80();
    t_p68();
    t_ser();
    t_i2c();
    results();
  end
  initial begin
    #20000;
    n_errors++;
    results();
  end
endmodule
`default_nettype wire
